// [rtl/nvc_host.v]
/*
  Host controller for an asynchronous nonvolatile SRAM: drives select,
  write and output strobes, address, data and the store/busy line.
  Runs single reads and writes, six-read software command sequences and
  hardware store requests, then waits out the device's lockout times.
  Assumes the device pins reach it directly; pin inputs are synchronised.
*/
`timescale 1ns/10ps
`include "nvc_defs.vh"
module nvc_host #(
  parameter AW           = 15,
  parameter DW           = 8,
  parameter HRECALL_CYC  = `NVC_HRECALL_CYC,
  parameter STORE_CYC    = `NVC_STORE_CYC,
  parameter RECALL_CYC   = `NVC_RECALL_CYC,
  parameter SS_CYC       = `NVC_SS_CYC
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              rst,
  // User command port
  input  wire              cmd_valid,
  output wire              cmd_ready,
  input  wire [1:0]        cmd_op,
  input  wire [AW-1:0]     cmd_addr,
  input  wire [DW-1:0]     cmd_wdata,
  input  wire [6*AW-1:0]   cmd_seq_addr,
  input  wire              cmd_seq_recall,
  output reg               rsp_valid_q,
  output reg  [DW-1:0]     rsp_rdata_q,
  output wire              nv_busy,
  // Device strobes and address
  output reg               sel_n_q,
  output reg               wr_n_q,
  output reg               oe_n_q,
  output reg  [AW-1:0]     addr_q,
  // Device data pins
  input  wire [DW-1:0]     dq_in,
  output reg  [DW-1:0]     dq_out_q,
  output reg               dq_oe_q,
  // Store request / busy line, open drain
  input  wire              store_request_busy_line_in,
  output wire              store_request_busy_line_out,
  output reg               store_request_busy_line_oe_q
);
  reg [2:0]            st_q;
  reg [`NVC_CNT_W-1:0] cnt_q;
  reg [2:0]            seq_idx_q;
  reg                  seq_rcl_q;
  reg [6*AW-1:0]       seq_addr_q;
  wire                 busy_lvl;
  wire [DW-1:0]        dq_sync;

  assign store_request_busy_line_out = 1'b0;
  assign cmd_ready = (st_q == `NVC_ST_IDLE);
  assign nv_busy   = ~cmd_ready;

  nvc_sync3 #(.RST_VAL(1'b1)) u_busy_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pin_in  (store_request_busy_line_in),
    .level_q (busy_lvl)
  );

  genvar gi;
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_dq_sync
      nvc_sync3 #(.RST_VAL(1'b0)) u_dq_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  (dq_in[gi]),
        .level_q (dq_sync[gi])
      );
    end
  endgenerate

  // Picks one command address from the six packed words
  function [AW-1:0] seq_word;
    input [6*AW-1:0] words;
    input [2:0]      idx;
    begin
      seq_word = words[idx*AW +: AW];
    end
  endfunction

  // Counter width chosen for the 20 ms figure at 125 MHz
  localparam integer I_RD   = `NVC_RD_CYC + 3;
  localparam integer I_WR   = `NVC_WR_CYC;
  localparam integer I_WP   = `NVC_WP_CYC;
  localparam integer I_PH   = `NVC_PHSB_CYC;
  localparam integer I_HH   = `NVC_HHHD_CYC + 3;
  localparam integer I_HRC  = HRECALL_CYC;
  localparam integer I_STR  = STORE_CYC;
  localparam integer I_RCL  = RECALL_CYC;
  localparam integer I_SS   = SS_CYC;
  localparam integer I_ONE  = 1;
  localparam integer I_LAST = `NVC_SEQ_LEN - 1;
  localparam [`NVC_CNT_W-1:0] C_RD   = I_RD[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_WR   = I_WR[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_WP   = I_WP[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_PH   = I_PH[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_HH   = I_HH[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_HRC  = I_HRC[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_STR  = I_STR[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_RCL  = I_RCL[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_SS   = I_SS[`NVC_CNT_W-1:0];
  localparam [`NVC_CNT_W-1:0] C_ONE  = I_ONE[`NVC_CNT_W-1:0];
  localparam [2:0]            C_LAST = I_LAST[2:0];

  always @(posedge mclk) begin
    if (rst) begin
      st_q                         <= `NVC_ST_PWRUP;
      cnt_q                        <= {`NVC_CNT_W{1'b0}};
      seq_idx_q                    <= 3'h0;
      seq_rcl_q                    <= 1'b0;
      seq_addr_q                   <= {6*AW{1'b0}};
      rsp_valid_q                  <= 1'b0;
      rsp_rdata_q                  <= {DW{1'b0}};
      sel_n_q                      <= 1'b1;
      wr_n_q                       <= 1'b1;
      oe_n_q                       <= 1'b1;
      addr_q                       <= {AW{1'b0}};
      dq_out_q                     <= {DW{1'b0}};
      dq_oe_q                      <= 1'b0;
      store_request_busy_line_oe_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (st_q)
        `NVC_ST_PWRUP: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q >= C_HRC - C_ONE) begin
            cnt_q <= {`NVC_CNT_W{1'b0}};
            st_q  <= `NVC_ST_IDLE;
          end
        end
        `NVC_ST_IDLE: begin
          cnt_q <= {`NVC_CNT_W{1'b0}};
          // access only with busy line high
          if (cmd_valid && busy_lvl) begin
            case (cmd_op)
              `NVC_CMD_READ: begin
                addr_q  <= cmd_addr;
                sel_n_q <= 1'b0;
                oe_n_q  <= 1'b0;
                st_q    <= `NVC_ST_RD;
              end
              `NVC_CMD_WRITE: begin
                // write low in the same cycle as select; output strobe high keeps device float
                addr_q   <= cmd_addr;
                dq_out_q <= cmd_wdata;
                dq_oe_q  <= 1'b1;
                wr_n_q   <= 1'b0;
                sel_n_q  <= 1'b0;
                st_q     <= `NVC_ST_WR;
              end
              `NVC_CMD_SEQ: begin
                seq_addr_q <= cmd_seq_addr;
                seq_rcl_q  <= cmd_seq_recall;
                seq_idx_q  <= 3'h0;
                addr_q     <= seq_word(cmd_seq_addr, 3'h0);
                sel_n_q    <= 1'b0;
                oe_n_q     <= 1'b0;
                st_q       <= `NVC_ST_SEQ;
              end
              default: begin
                store_request_busy_line_oe_q <= 1'b1;
                st_q                         <= `NVC_ST_HSPULSE;
              end
            endcase
          end
        end
        // write strobe held high while reading
        `NVC_ST_RD: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q >= C_RD - C_ONE) begin
            rsp_rdata_q <= dq_sync;
            rsp_valid_q <= 1'b1;
            sel_n_q     <= 1'b1;
            oe_n_q      <= 1'b1;
            st_q        <= `NVC_ST_IDLE;
          end
        end
        `NVC_ST_WR: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == C_WP - C_ONE) begin
            wr_n_q  <= 1'b1;
            sel_n_q <= 1'b1;
          end
          if (cnt_q >= C_WR) begin
            dq_oe_q <= 1'b0;
            st_q    <= `NVC_ST_IDLE;
          end
        end
        `NVC_ST_SEQ: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == C_RD - C_ONE) begin
            sel_n_q <= 1'b1;
            oe_n_q  <= 1'b1;
          end
          if (cnt_q >= C_RD) begin
            cnt_q <= {`NVC_CNT_W{1'b0}};
            if (seq_idx_q == C_LAST) begin
              st_q <= `NVC_ST_SEQWAIT;
            end else begin
              seq_idx_q <= seq_idx_q + 3'h1;
              addr_q    <= seq_word(seq_addr_q, seq_idx_q + 3'h1);
              sel_n_q   <= 1'b0;
              oe_n_q    <= 1'b0;
            end
          end
        end
        `NVC_ST_SEQWAIT: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q >= C_SS + (seq_rcl_q ? C_RCL : C_STR) - C_ONE) begin
            cnt_q <= {`NVC_CNT_W{1'b0}};
            st_q  <= `NVC_ST_IDLE;
          end
        end
        `NVC_ST_HSPULSE: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q >= C_PH - C_ONE) begin
            store_request_busy_line_oe_q <= 1'b0;
            cnt_q                        <= {`NVC_CNT_W{1'b0}};
            st_q                         <= `NVC_ST_HSBUSY;
          end
        end
        // wait while device holds line busy
        `NVC_ST_HSBUSY: begin
          cnt_q <= cnt_q + C_ONE;
          // Line high past settle window ends it; skipped store never goes low
          if (cnt_q >= C_HH && busy_lvl) begin
            cnt_q <= {`NVC_CNT_W{1'b0}};
            st_q  <= `NVC_ST_IDLE;
          end else if (cnt_q >= C_HH + C_STR) begin
            cnt_q <= {`NVC_CNT_W{1'b0}};
            st_q  <= `NVC_ST_IDLE;
          end
        end
        default: st_q <= `NVC_ST_IDLE;
      endcase
    end
  end
endmodule // nvc_host

// [rtl/nvc_defs.vh]
/*
  Constants shared by the nonvolatile SRAM host controller: pin timing
  in nanoseconds, microseconds and milliseconds and derived cycle counts, state codes, command codes.
  Assumes a 125 MHz mclk, so one cycle is 8 ns.

*/
`ifndef NVC_DEFS_VH
`define NVC_DEFS_VH

`define NVC_CLK_NS        8
`define NVC_RC_NS         25
`define NVC_PWE_NS        20
`define NVC_DOE_NS        25
`define NVC_PHSB_NS       15
`define NVC_DELAY_NS      25
`define NVC_HHHD_NS       500
`define NVC_SS_US         100
`define NVC_RECALL_US     200
`define NVC_STORE_MS      8
`define NVC_HRECALL_MS    20

// Least times round up, never under one cycle
`define NVC_CYC_UP(ns)    (((ns) + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_RD_CYC        `NVC_CYC_UP(`NVC_RC_NS)
`define NVC_WR_CYC        `NVC_CYC_UP(`NVC_RC_NS)
`define NVC_WP_CYC        `NVC_CYC_UP(`NVC_PWE_NS)
`define NVC_PHSB_CYC      `NVC_CYC_UP(`NVC_PHSB_NS)
`define NVC_DELAY_CYC     `NVC_CYC_UP(`NVC_DELAY_NS)
`define NVC_HHHD_CYC      `NVC_CYC_UP(`NVC_HHHD_NS)
`define NVC_SS_CYC        (`NVC_SS_US * 1000 / `NVC_CLK_NS)
`define NVC_RECALL_CYC    (`NVC_RECALL_US * 1000 / `NVC_CLK_NS)
`define NVC_STORE_CYC     (`NVC_STORE_MS * 1000000 / `NVC_CLK_NS)
`define NVC_HRECALL_CYC   (`NVC_HRECALL_MS * 1000000 / `NVC_CLK_NS)

`define NVC_CNT_W         22

// Host commands
`define NVC_CMD_READ      2'h0
`define NVC_CMD_WRITE     2'h1
`define NVC_CMD_SEQ       2'h2
`define NVC_CMD_HWSTORE   2'h3

// States
`define NVC_ST_PWRUP      3'h0
`define NVC_ST_IDLE       3'h1
`define NVC_ST_RD         3'h2
`define NVC_ST_WR         3'h3
`define NVC_ST_SEQ        3'h4
`define NVC_ST_SEQWAIT    3'h5
`define NVC_ST_HSPULSE    3'h6
`define NVC_ST_HSBUSY     3'h7

`define NVC_SEQ_LEN       6

`endif

// [rtl/nvc_sync3.v]
/*
  Three-flop input synchroniser with agreement of the last two stages.
  Assumes an asynchronous pin input and one clock domain.
*/
`timescale 1ns/10ps
module nvc_sync3 #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Pin and clean level
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge mclk) begin
    if (rst) begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only once stages two and three agree
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end
endmodule // nvc_sync3

// [verif/nvc_dev_model.sv]
/* Behavioural device on the far side of nvc_host.
   Assumes mclk only paces the model; a store holds busy HOLD cycles. */
`timescale 1ns/10ps
module nvc_dev_model #(
  parameter HOLD = 80
) (
  // Pacing clock
  input  wire        mclk,
  // SRAM pins
  input  wire        sel_n,
  input  wire        wr_n,
  input  wire        oe_n,
  input  wire [14:0] addr,
  input  wire [7:0]  din,
  output reg  [7:0]  dout,
  // Busy line
  input  wire        line_in,
  output reg         line_pull
);
  reg [7:0] mem [0:32767];
  reg       dirty_q = 1'b0;
  reg       sel_d   = 1'b1;
  reg       wrs_q   = 1'b0;
  integer   busy    = 0;
  initial dout = 8'h00;
  initial line_pull = 1'b0;
  always @(posedge mclk) begin
    sel_d <= sel_n;
    if (sel_n) wrs_q <= 1'b0;
    else if (sel_d) wrs_q <= !wr_n;
    if (!sel_n && !sel_d && wr_n && !oe_n && !wrs_q && busy == 0) dout <= mem[addr];
    else dout <= ~dout;
    // write when idle; one at store start still lands
    if (!sel_n && !wr_n && busy == 0) begin
      mem[addr] <= din;
      dirty_q <= 1'b1;
    end
    if (busy > 0) begin
      busy <= busy - 1;
      line_pull <= busy > 1;
    end else if (!line_in && !line_pull && dirty_q) begin
      busy <= HOLD;
      line_pull <= 1'b1;
      dirty_q <= 1'b0;
    end
  end
endmodule // nvc_dev_model

// [verif/nvc_host_props.sv]
/* Pin checks for nvc_host.
   Assumes binding to the host module; sees only its ports. */
`timescale 1ns/10ps
module nvc_host_props (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Watched pins
  input wire cmd_ready,
  input wire rsp_valid_q,
  input wire sel_n_q,
  input wire wr_n_q,
  input wire oe_n_q,
  input wire dq_oe_q,
  input wire store_request_busy_line_in,
  input wire store_request_busy_line_oe_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_read_wr_high: assert property (!oe_n_q |-> wr_n_q)
    else $error("write low in read");
  a_busy_quiet: assert property (!sel_n_q |-> !store_request_busy_line_oe_q)
    else $error("busy pulled in access");
  a_store_pulse: assert property ($rose(store_request_busy_line_oe_q) |=>
    store_request_busy_line_oe_q ##1 !store_request_busy_line_oe_q)
    else $error("store pulse width");
  a_write_strobe: assert property ($fell(wr_n_q) |->
    (!sel_n_q && dq_oe_q)[*3] ##1 wr_n_q) else $error("write strobe");
  a_read_hold: assert property ($fell(oe_n_q) |-> (!sel_n_q)[*4])
    else $error("read too short");
  a_line_lock: assert property (!store_request_busy_line_in |-> sel_n_q)
    else $error("access while busy");
  a_rsp_single: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("response pulse");
  a_pull_locks: assert property (store_request_busy_line_oe_q |-> !cmd_ready)
    else $error("ready while pulling");
  c_read: cover property (rsp_valid_q);
  c_store: cover property ($rose(store_request_busy_line_oe_q));
  c_write: cover property ($fell(wr_n_q));
endmodule // nvc_host_props
bind nvc_host nvc_host_props u_props (.mclk(mclk), .rst(rst), .cmd_ready(cmd_ready),
  .rsp_valid_q(rsp_valid_q), .sel_n_q(sel_n_q), .wr_n_q(wr_n_q), .oe_n_q(oe_n_q),
  .dq_oe_q(dq_oe_q), .store_request_busy_line_in(store_request_busy_line_in),
  .store_request_busy_line_oe_q(store_request_busy_line_oe_q));

// [verif/testbench.sv]
/* Self-checking bench for nvc_host with shortened lockout counts.
   Assumes the behavioural device model; busy line has a pull-up. */
`timescale 1ns/10ps
module testbench;
  localparam AW   = 15;
  localparam HRC  = 20;
  localparam HOLD = 80;
  reg            mclk = 1'b0;
  reg            rst = 1'b1;
  reg            cmd_valid = 1'b0;
  reg  [1:0]     cmd_op = 2'h0;
  reg  [AW-1:0]  cmd_addr = 15'h0000;
  reg  [7:0]     cmd_wdata = 8'h00;
  reg  [6*AW-1:0] cmd_seq_addr = {15'h4C63, 15'h3B1C, 15'h0FC0, 15'h703F, 15'h4C63, 15'h0E38};
  reg            cmd_seq_recall = 1'b0;
  wire           cmd_ready, rsp_valid_q, sel_n_q, wr_n_q, oe_n_q, dq_oe_q, line_oe, dev_pull;
  wire           nv_busy, line_out;
  wire [AW-1:0]  addr_q;
  wire [7:0]     rsp_rdata_q, dq_out_q, dev_dq;
  // Open drain line with pull-up, either side pulls low
  wire           busy_line = (line_oe ? line_out : 1'b1) && !dev_pull;
  wire [7:0]     dq = dq_oe_q ? dq_out_q : dev_dq;
  integer        failures = 0, check_count = 0, cyc, nrd = 0, k, nrsp = 0, base = 0;
  integer        tcnt = 0, t_rise = 0;
  reg            sel_d = 1'b1;
  reg  [AW-1:0]  seen [0:7];
  reg  [7:0]     rd;
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    sel_d <= sel_n_q;
    tcnt <= tcnt + 1;
    if (!sel_d && sel_n_q)
      t_rise <= tcnt;
    if (sel_d && !sel_n_q) begin
      seen[nrd%8] <= addr_q;
      nrd <= nrd + 1;
    end
  end
  nvc_host #(.HRECALL_CYC(HRC), .STORE_CYC(30), .RECALL_CYC(20), .SS_CYC(10)) u_dut (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_seq_addr(cmd_seq_addr),
    .cmd_seq_recall(cmd_seq_recall), .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q),
    .nv_busy(nv_busy), .sel_n_q(sel_n_q), .wr_n_q(wr_n_q), .oe_n_q(oe_n_q), .addr_q(addr_q),
    .dq_in(dq), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q),
    .store_request_busy_line_in(busy_line), .store_request_busy_line_out(line_out),
    .store_request_busy_line_oe_q(line_oe));
  nvc_dev_model #(.HOLD(HOLD)) u_dev (.mclk(mclk), .sel_n(sel_n_q), .wr_n(wr_n_q),
    .oe_n(oe_n_q), .addr(addr_q), .din(dq), .dout(dev_dq), .line_in(busy_line),
    .line_pull(dev_pull));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Issue one request, count cycles until idle again
  task run(input [1:0] op, input [AW-1:0] a, input [7:0] d);
    begin
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cyc = 0;
      nrsp = 0;
      do begin
        @(posedge mclk);
        cyc = cyc + 1;
        if (cyc == 1) chk(nv_busy, 1);
        if (rsp_valid_q === 1'b1) begin
          rd = rsp_rdata_q;
          nrsp = nrsp + 1;
        end
      end while (cmd_ready !== 1'b1 && cyc < 400);
      if (cyc >= 400) begin
        failures = failures + 1;
        complete_run;
      end
      chk(nv_busy, 0);
    end
  endtask
  task t_powerup;
    begin
      for (cyc = 0; cyc < 200 && cmd_ready !== 1'b1; cyc = cyc + 1) @(posedge mclk);
      chk(cyc >= HRC - 1 && cyc < 200, 1);
      $display("powerup test done");
    end
  endtask
  task t_wr_rd;
    begin
      run(2'h1, 15'h0000, 8'h5A);
      run(2'h1, 15'h7FFF, 8'hA5);
      run(2'h0, 15'h0000, 8'h00);
      chk(rd, 8'h5A);
      chk(nrsp, 1);
      run(2'h0, 15'h7FFF, 8'h00);
      chk(rd, 8'hA5);
      $display("write read test done");
    end
  endtask
  task t_hwstore;
    begin
      run(2'h1, 15'h0010, 8'h3C);
      run(2'h3, 15'h0000, 8'h00);
      chk(cyc >= HOLD, 1);
      run(2'h3, 15'h0000, 8'h00);
      chk(cyc < HOLD, 1);
      run(2'h0, 15'h0010, 8'h00);
      chk(rd, 8'h3C);
      $display("store test done");
    end
  endtask
  task t_seq;
    integer r;
    begin
      for (r = 0; r < 2; r = r + 1) begin
        base = nrd;
        cmd_seq_recall <= r[0];
        run(2'h2, 15'h0000, 8'h00);
        chk(nrd - base, 6);
        for (k = 0; k < 6; k = k + 1)
          chk(seen[(base + k) % 8], cmd_seq_addr[k*AW +: AW]);
        chk(nrsp, 0);
        // Lockout is timed from the last select rise
        chk(tcnt - t_rise >= (r ? 30 : 40), 1);
      end
      $display("sequence test done");
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_powerup;
    t_wr_rd;
    t_hwstore;
    t_seq;
    complete_run;
  end
endmodule // testbench
